// file: core/cmc_pkg.sv
// Constants shared by the channel main control block.
`default_nettype none
package cmc_pkg;
    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] CMC_CTRL_OFFSET = 8'h0C;
    localparam logic [15:0] CMC_CTRL_RESET = 16'h0000;
    // ========================================================================
    // Field positions of the main control register
    // ========================================================================
    localparam int CMC_BIT_IMM_UPDATE = 15;
    localparam int CMC_BIT_GAIN_HOLD = 14;
    localparam int CMC_BIT_DELAY_SEL = 13;
    localparam int CMC_BIT_COEF_HOLD = 12;
    localparam int CMC_BIT_INT_TX_GATE = 11;
    localparam int CMC_AE_THR_MSB = 10;
    localparam int CMC_AE_THR_LSB = 8;
    localparam int CMC_BIT_COMPLEX_OUT = 7;
    localparam int CMC_BIT_ONLINE = 6;
    localparam int CMC_BIT_INPUT_EN = 5;
    localparam int CMC_BIT_OUTPUT_EN = 4;
    localparam int CMC_BIT_SIB_FREE = 3;
    localparam int CMC_BIT_NO_TX_FLUSH = 2;
    localparam int CMC_BIT_NO_OVF_RESET = 1;
    localparam int CMC_BIT_SW_TX = 0;
    // ========================================================================
    // Timing counts
    // ========================================================================
    localparam int CMC_IMM_SYNC_CLKS = 4;
    localparam int CMC_RAM_FLUSH_CLKS = 16;
    localparam int CMC_OFFLINE_FLUSH_SAMPLES = 24;
endpackage : cmc_pkg
`default_nettype wire

// file: core/cmc_route_if.sv
// Control bits passed from the control register to the output router.
`default_nettype none
interface cmc_route_if;
    logic complex_en;
    logic out_en;
    modport ctrl (output complex_en, output out_en);
    modport route (input complex_en, input out_en);
endinterface : cmc_route_if
`default_nettype wire

// file: core/cmc_flush_timer.sv
// Down counter that times one flush and pulses when it finishes.
`default_nettype none
module cmc_flush_timer #(
    parameter int STEPS = 16
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic step_in,
    output logic busy_out,
    output logic done_out
);
    localparam int CW = $clog2(STEPS + 1);
    localparam logic [CW-1:0] LOAD = CW'(STEPS);
    logic [CW-1:0] count_reg;

    // ========================================================================
    // Counter
    // ========================================================================
    // A new start reloads the full count, so a retrigger extends the flush.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            count_reg <= '0;
        else if (abort_in)
            count_reg <= '0;
        else if (start_in)
            count_reg <= LOAD;
        else if (step_in && count_reg != '0)
            count_reg <= count_reg - CW'(1);
    end

    // The done pulse marks the step that empties the counter.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            done_out <= 1'b0;
        else
            done_out <= !abort_in && !start_in && step_in && count_reg == CW'(1);
    end

    assign busy_out = (count_reg != '0);
endmodule : cmc_flush_timer
`default_nettype wire

// file: core/cmc_out_route.sv
// Output selection and output enable of one channel.
`default_nettype none
module cmc_out_route #(
    parameter int DW = 20,
    parameter int CHANNEL_ID = 0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    cmc_route_if.route ctl,
    input wire logic four_ch_real_mode_in,
    input wire logic [DW-1:0] real_sum_two_in,
    input wire logic [DW-1:0] imag_sum_one_in,
    input wire logic [DW-1:0] real_sum_four_in,
    input wire logic [DW-1:0] imag_sum_three_in,
    input wire logic [DW-1:0] own_sum_in,
    output logic [DW-1:0] data_out
);
    logic [DW-1:0] pick;

    // ========================================================================
    // Source selection
    // ========================================================================
    // Only channels 0 and 2 own a swap; channels 1 and 3 ignore complex mode.
    always_comb
    begin
        pick = own_sum_in;
        if (CHANNEL_ID == 0)
            pick = (ctl.complex_en && four_ch_real_mode_in) ? imag_sum_one_in
                                                             : real_sum_two_in;
        else if (CHANNEL_ID == 2)
            pick = (ctl.complex_en && four_ch_real_mode_in) ? imag_sum_three_in
                                                             : real_sum_four_in;
    end

    // Disabled output is forced to zero rather than held.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            data_out <= '0;
        else
            data_out <= ctl.out_en ? pick : '0;
    end

    property p_out_zero;
        @(posedge clk_in) disable iff (!nrst_in)
        !ctl.out_en |=> data_out == '0;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("output not cleared");

    property p_out_pass;
        @(posedge clk_in) disable iff (!nrst_in)
        ctl.out_en |=> data_out == $past(pick);
    endproperty
    a_out_pass: assert property (p_out_pass) else $error("output not passed");
endmodule : cmc_out_route
`default_nettype wire

// file: core/cmc_main_ctrl.sv
// Per-channel main control register and the channel controls it drives.
`default_nettype none
module cmc_main_ctrl #(
    parameter int NREG = 8,
    parameter int CW = 16,
    parameter int DW = 20,
    parameter int FW = 4,
    parameter int GAW = 7,
    parameter int GW = 12,
    parameter int CHANNEL_ID = 0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    input wire logic [NREG-1:0] cfg_write_in,
    input wire logic [NREG-1:0][CW-1:0] cfg_master_in,
    input wire logic [NREG-1:0] update_mask_in,
    output logic [NREG-1:0][CW-1:0] cfg_slave_out,
    input wire logic ext_tx_gate_pin_in,
    input wire logic hw_update_pin_in,
    input wire logic int_tx_gate_in,
    output logic channel_transmit_gate_out,
    input wire logic [GAW-1:0] ramp_addr_in,
    input wire logic [GW-1:0] ramp_gain_in,
    output logic [GAW-1:0] gain_addr_out,
    output logic [GW-1:0] gain_value_out,
    output logic gain_host_access_out,
    output logic coef_host_access_out,
    input wire logic coarse_half_strobe_in,
    input wire logic [DW-1:0] fir_i_in,
    input wire logic [DW-1:0] fir_q_in,
    output logic [DW-1:0] fir_i_out,
    output logic [DW-1:0] fir_q_out,
    input wire logic [FW-1:0] i_fifo_level_in,
    input wire logic [FW-1:0] q_fifo_level_in,
    output logic i_almost_empty_out,
    output logic q_almost_empty_out,
    input wire logic sample_strobe_in,
    output logic fifo_rd_zero_out,
    output logic channel_flushed_flag_out,
    output logic serial_input_block_run_out,
    output logic channel_flush_out,
    output logic ram_flush_busy_out,
    input wire logic parallel_mode_in,
    input wire logic fifo_overflow_in,
    output logic channel_reset_out,
    output logic serial_req_allow_out,
    input wire logic four_ch_real_mode_in,
    input wire logic [DW-1:0] real_sum_two_in,
    input wire logic [DW-1:0] imag_sum_one_in,
    input wire logic [DW-1:0] real_sum_four_in,
    input wire logic [DW-1:0] imag_sum_three_in,
    input wire logic [DW-1:0] own_sum_in,
    output logic [DW-1:0] data_out
);
    localparam int PD = cmc_pkg::CMC_IMM_SYNC_CLKS - 1;

    logic [15:0] ctrl_reg;
    logic ctrl_hit;
    logic [1:0] ext_gate_sync_reg;
    logic [1:0] upd_sync_reg;
    logic gate_prev_reg;
    logic sw_tx_prev_reg;
    logic online_prev_reg;
    logic [NREG-1:0] imm_pipe_reg [PD];
    logic sel_gate;
    logic hw_update;
    logic gate_rise;
    logic sw_rise;
    logic sync_update;
    logic [2:0] ae_thr;
    logic [DW-1:0] i_half_reg;
    logic [DW-1:0] q_half_reg;
    logic offline_done;

    // ========================================================================
    // Control register
    // ========================================================================
    assign ctrl_hit = (host_addr_in == cmc_pkg::CMC_CTRL_OFFSET);

    // Host writes land whole; no field has a side effect on write itself.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ctrl_reg <= cmc_pkg::CMC_CTRL_RESET;
        else if (host_wr_in && ctrl_hit)
            ctrl_reg <= host_wdata_in;
    end

    // Read data is registered; other addresses return zero.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            host_rdata_out <= 16'h0000;
        else if (host_rd_in)
            host_rdata_out <= ctrl_hit ? ctrl_reg : 16'h0000;
    end

    // ========================================================================
    // Pin synchronisers and transmit gate
    // ========================================================================
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ext_gate_sync_reg <= 2'h0;
            upd_sync_reg <= 2'h0;
        end
        else
        begin
            ext_gate_sync_reg <= {ext_gate_sync_reg[0], ext_tx_gate_pin_in};
            upd_sync_reg <= {upd_sync_reg[0], hw_update_pin_in};
        end
    end

    // Internal gate comes from the on-chip timing logic, already in this clock.
    assign sel_gate = ctrl_reg[cmc_pkg::CMC_BIT_INT_TX_GATE] ? int_tx_gate_in
                                                              : ext_gate_sync_reg[1];
    assign channel_transmit_gate_out = sel_gate && ctrl_reg[cmc_pkg::CMC_BIT_INPUT_EN];
    assign hw_update = upd_sync_reg[1] && ctrl_reg[cmc_pkg::CMC_BIT_INPUT_EN];

    // Edge history for gate, software enable and online bit.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            gate_prev_reg <= 1'b0;
            sw_tx_prev_reg <= 1'b0;
            online_prev_reg <= 1'b1;
        end
        else
        begin
            gate_prev_reg <= channel_transmit_gate_out;
            sw_tx_prev_reg <= ctrl_reg[cmc_pkg::CMC_BIT_SW_TX];
            online_prev_reg <= ctrl_reg[cmc_pkg::CMC_BIT_ONLINE];
        end
    end

    assign gate_rise = channel_transmit_gate_out && !gate_prev_reg;
    assign sw_rise = ctrl_reg[cmc_pkg::CMC_BIT_SW_TX] && !sw_tx_prev_reg;

    // ========================================================================
    // Slave configuration registers
    // ========================================================================
    // Immediate writes are delayed so the slave never loads mid-sample.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int s = 0; s < PD; s++)
                imm_pipe_reg[s] <= '0;
        end
        else
        begin
            imm_pipe_reg[0] <= ctrl_reg[cmc_pkg::CMC_BIT_IMM_UPDATE] ? cfg_write_in : '0;
            for (int s = 1; s < PD; s++)
                imm_pipe_reg[s] <= imm_pipe_reg[s-1];
        end
    end

    assign sync_update = !ctrl_reg[cmc_pkg::CMC_BIT_IMM_UPDATE] && (hw_update || sw_rise);

    // A masked synchronous load and a delayed immediate load share one copy path.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cfg_slave_out <= '0;
        else
        begin
            for (int r = 0; r < NREG; r++)
                if ((sync_update && update_mask_in[r]) || imm_pipe_reg[PD-1][r])
                    cfg_slave_out[r] <= cfg_master_in[r];
        end
    end

    // ========================================================================
    // Gain profile and coefficient access
    // ========================================================================
    // While held the last ramp point stays on the output for the host to reload.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            gain_addr_out <= '0;
            gain_value_out <= '0;
        end
        else if (!ctrl_reg[cmc_pkg::CMC_BIT_GAIN_HOLD])
        begin
            gain_addr_out <= ramp_addr_in;
            gain_value_out <= ramp_gain_in;
        end
    end

    assign gain_host_access_out = ctrl_reg[cmc_pkg::CMC_BIT_GAIN_HOLD];
    assign coef_host_access_out = ctrl_reg[cmc_pkg::CMC_BIT_COEF_HOLD];

    // ========================================================================
    // Half coarse sample delay after the FIR
    // ========================================================================
    // The strobe ticks at twice the coarse rate, so one stage is half a sample.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            i_half_reg <= '0;
            q_half_reg <= '0;
        end
        else if (coarse_half_strobe_in)
        begin
            i_half_reg <= fir_i_in;
            q_half_reg <= fir_q_in;
        end
    end

    assign fir_i_out = ctrl_reg[cmc_pkg::CMC_BIT_DELAY_SEL] ? i_half_reg : fir_i_in;
    assign fir_q_out = ctrl_reg[cmc_pkg::CMC_BIT_DELAY_SEL] ? q_half_reg : fir_q_in;

    // ========================================================================
    // FIFO almost empty
    // ========================================================================
    // The threshold is programmed as count minus one, so the flag covers equality.
    assign ae_thr = ctrl_reg[cmc_pkg::CMC_AE_THR_MSB:cmc_pkg::CMC_AE_THR_LSB];
    assign i_almost_empty_out = i_fifo_level_in <= FW'(ae_thr);
    assign q_almost_empty_out = q_fifo_level_in <= FW'(ae_thr);

    // ========================================================================
    // Online and offline flushing
    // ========================================================================
    assign fifo_rd_zero_out = !ctrl_reg[cmc_pkg::CMC_BIT_ONLINE];

    cmc_flush_timer #(.STEPS(cmc_pkg::CMC_OFFLINE_FLUSH_SAMPLES)) u_offline_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(fifo_rd_zero_out && online_prev_reg),
        .abort_in(!fifo_rd_zero_out),
        .step_in(sample_strobe_in),
        .busy_out(),
        .done_out(offline_done)
    );

    // Completion holds until the channel goes back online.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            channel_flushed_flag_out <= 1'b0;
        else if (offline_done)
            channel_flushed_flag_out <= 1'b1;
        else if (!fifo_rd_zero_out)
            channel_flushed_flag_out <= 1'b0;
    end

    // ========================================================================
    // Gate and software driven flushes, serial block and overflow reset
    // ========================================================================
    // With gating off the serial block runs on, so the source must send zeros.
    assign serial_input_block_run_out = ctrl_reg[cmc_pkg::CMC_BIT_SIB_FREE]
                                        || channel_transmit_gate_out;
    assign serial_req_allow_out = ctrl_reg[cmc_pkg::CMC_BIT_SW_TX];

    cmc_flush_timer #(.STEPS(cmc_pkg::CMC_RAM_FLUSH_CLKS)) u_ram_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(sw_rise),
        .abort_in(1'b0),
        .step_in(1'b1),
        .busy_out(ram_flush_busy_out),
        .done_out()
    );

    // The flush is a one-cycle pulse; the reset stays high while the overflow lasts. Both are registered.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            channel_flush_out <= 1'b0;
            channel_reset_out <= 1'b0;
        end
        else
        begin
            channel_flush_out <= gate_rise && !ctrl_reg[cmc_pkg::CMC_BIT_NO_TX_FLUSH];
            channel_reset_out <= parallel_mode_in && fifo_overflow_in
                                 && !ctrl_reg[cmc_pkg::CMC_BIT_NO_OVF_RESET];
        end
    end

    // ========================================================================
    // Output routing
    // ========================================================================
    cmc_route_if rif ();
    assign rif.complex_en = ctrl_reg[cmc_pkg::CMC_BIT_COMPLEX_OUT];
    assign rif.out_en = ctrl_reg[cmc_pkg::CMC_BIT_OUTPUT_EN];

    cmc_out_route #(.DW(DW), .CHANNEL_ID(CHANNEL_ID)) u_route (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ctl(rif.route),
        .four_ch_real_mode_in(four_ch_real_mode_in),
        .real_sum_two_in(real_sum_two_in),
        .imag_sum_one_in(imag_sum_one_in),
        .real_sum_four_in(real_sum_four_in),
        .imag_sum_three_in(imag_sum_three_in),
        .own_sum_in(own_sum_in),
        .data_out(data_out)
    );

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_imm_load;
        (ctrl_reg[15] && cfg_write_in[0]) |-> ##4 cfg_slave_out[0] == $past(cfg_master_in[0]);
    endproperty
    a_imm_load: assert property (p_imm_load) else $error("immediate load missed");

    property p_sync_load;
        (sync_update && update_mask_in[0]) |=> cfg_slave_out[0] == $past(cfg_master_in[0]);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load missed");

    property p_mask_off;
        (!sync_update || !update_mask_in[0]) && !imm_pipe_reg[PD-1][0] |=> $stable(cfg_slave_out[0]);
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("unselected slave moved");

    property p_gain_hold;
        ctrl_reg[14] && $past(ctrl_reg[14]) |-> $stable(gain_value_out) && $stable(gain_addr_out);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain moved under hold");

    property p_ram_flush;
        sw_rise |=> ram_flush_busy_out [*8];
    endproperty
    a_ram_flush: assert property (p_ram_flush) else $error("ram flush too short");

    property p_flushed_src;
        $rose(channel_flushed_flag_out) |-> $past(fifo_rd_zero_out, 2) && $past(offline_done);
    endproperty
    a_flushed_src: assert property (p_flushed_src) else $error("flushed flag spurious");

    property p_tx_flush;
        gate_rise |=> channel_flush_out == !$past(ctrl_reg[2]);
    endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("gate flush wrong");

    property p_ovf;
        channel_reset_out |-> $past(parallel_mode_in && fifo_overflow_in) && !$past(ctrl_reg[1]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow reset wrong");

    property p_sib;
        !ctrl_reg[3] && !channel_transmit_gate_out |-> !serial_input_block_run_out;
    endproperty
    a_sib: assert property (p_sib) else $error("serial block ran ungated");

    c_imm: cover property (ctrl_reg[15] && cfg_write_in[0] ##4 1'b1);
    c_offline: cover property ($rose(channel_flushed_flag_out));
    c_sw_tx: cover property (sw_rise);
    c_gate_flush: cover property (channel_flush_out);
endmodule : cmc_main_ctrl
`default_nettype wire

// file: tb/cmc_host_model.sv
// Host model that writes and reads the channel control register.
`default_nettype none
module cmc_host_model (
    input wire logic clk_in,
    output var logic wr_out,
    output var logic rd_out,
    output var logic [7:0] addr_out,
    output var logic [15:0] data_out,
    input wire logic [15:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero; strobes low.
    initial
    begin
        wr_out = 1'h0;
        rd_out = 1'h0;
        addr_out = 8'h00;
        data_out = 16'h0000;
    end
    // One write; released lines show the inverse so stale values cannot pass.
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        wr_out = 1'h1;
        addr_out = a;
        data_out = d;
        @(negedge clk_in);
        wr_out = 1'h0;
        addr_out = ~a;
        data_out = ~d;
    endtask : wr
    // One read; data is taken in the cycle after the read edge.
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_in);
        rd_out = 1'h1;
        addr_out = a;
        @(negedge clk_in);
        rd_out = 1'h0;
        addr_out = ~a;
        d = rdata_in;
    endtask : rd
endmodule : cmc_host_model
`default_nettype wire

// file: tb/cmc_main_ctrl_tb.sv
// Self-checking bench for the channel main control block.
`default_nettype none
module cmc_main_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'h0, nrst_in = 1'h0, host_wr_in, host_rd_in;
    logic [7:0] host_addr_in, cfg_write_in = 8'h00, update_mask_in = 8'h00;
    logic [15:0] host_wdata_in, host_rdata_out;
    logic [7:0][15:0] cfg_master_in = 128'h0, cfg_slave_out;
    logic [19:0] s1 = 20'h0ABCD, s2 = 20'h12345, data_out, rv = 20'h0, fi;
    logic upd_pin = 1'h0, int_gate = 1'h0, gate, flush, serial_input_block, frz, gha, cha;
    logic [11:0] ramp = 12'h0AB, gv;
    logic [3:0] lvl = 4'h0;
    logic sample_strobe_in = 1'h1, parallel_mode_in = 1'h0, fifo_overflow_in = 1'h0;
    logic four_ch_real_mode_in = 1'h0, ext_tx_gate_pin_in = 1'h0, i_almost_empty_out;
    logic ram_flush_busy_out, channel_flushed_flag_out, serial_req_allow_out, channel_reset_out;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    // ========================================================================
    // Design, host and clock
    // ========================================================================
    cmc_main_ctrl cmc_main_ctrl_i (.clk_in, .nrst_in, .host_wr_in, .host_rd_in, .host_addr_in,
        .host_wdata_in, .host_rdata_out, .cfg_write_in, .cfg_master_in, .update_mask_in,
        .cfg_slave_out, .ext_tx_gate_pin_in, .hw_update_pin_in(upd_pin),
        .int_tx_gate_in(int_gate), .channel_transmit_gate_out(gate),
        .ramp_addr_in(7'h05), .ramp_gain_in(ramp), .gain_addr_out(), .gain_value_out(gv),
        .gain_host_access_out(gha), .coef_host_access_out(cha),
        .coarse_half_strobe_in(sample_strobe_in), .fir_i_in(s1), .fir_q_in(s2), .fir_i_out(fi),
        .fir_q_out(), .i_fifo_level_in(lvl), .q_fifo_level_in(lvl), .i_almost_empty_out,
        .q_almost_empty_out(), .sample_strobe_in, .fifo_rd_zero_out(frz),
        .channel_flushed_flag_out, .serial_input_block_run_out(serial_input_block), .channel_flush_out(flush),
        .ram_flush_busy_out, .parallel_mode_in, .fifo_overflow_in,
        .channel_reset_out, .serial_req_allow_out, .four_ch_real_mode_in, .real_sum_two_in(s2),
        .imag_sum_one_in(s1), .real_sum_four_in(s2), .imag_sum_three_in(s1), .own_sum_in(s1),
        .data_out);
    cmc_host_model cmc_host_model_i (.clk_in, .wr_out(host_wr_in), .rd_out(host_rd_in),
        .addr_out(host_addr_in), .data_out(host_wdata_in), .rdata_in(host_rdata_out));
    // Free-running 100 ns clock.
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end
    // Hang guard: the sequence needs well under 200 cycles.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // ========================================================================
    // Compare and closing tasks
    // ========================================================================
    task chk(input logic [19:0] g, input logic [19:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task chkb(input logic g, input logic e);
        chk({19'h0, g}, {19'h0, e});
    endtask : chkb
    task stop_test();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // ========================================================================
    // Test sequence
    // ========================================================================
    initial
    begin
        repeat (4) @(negedge clk_in);
        nrst_in = 1'h1;
        cmc_host_model_i.rd(8'h0C, rv[15:0]);
        chk(rv, 20'h0);
        chkb(channel_flushed_flag_out, 1'h0);
        cmc_host_model_i.wr(8'h0C, 16'h0010);
        @(negedge clk_in);
        chk(data_out, s2);
        cmc_host_model_i.rd(8'h0C, rv[15:0]);
        chk(rv, 20'h00010);
        cmc_host_model_i.rd(8'h2A, rv[15:0]);
        chk(rv, 20'h0);
        repeat (24) @(negedge clk_in);
        chkb(channel_flushed_flag_out, 1'h1);
        $display("test readback and offline flush done");
        four_ch_real_mode_in = 1'h1;
        cmc_host_model_i.wr(8'h0C, 16'h00D0);
        @(negedge clk_in);
        chkb(channel_flushed_flag_out, 1'h0);
        chk(data_out, s1);
        cmc_host_model_i.wr(8'h0C, 16'h0340);
        @(negedge clk_in);
        chk(data_out, 20'h0);
        for (int lv = 2; lv < 6; lv++)
        begin
            lvl = 4'(lv);
            @(negedge clk_in);
            chkb(i_almost_empty_out, lv <= 3);
        end
        $display("test routing and threshold done");
        update_mask_in = 8'h05;
        cfg_master_in[0] = 16'h1111;
        cfg_master_in[1] = 16'h2222;
        cmc_host_model_i.wr(8'h0C, 16'h0041);
        @(negedge clk_in);
        chkb(ram_flush_busy_out, 1'h1);
        chk({4'h0, cfg_slave_out[0]}, 20'h01111);
        chk({4'h0, cfg_slave_out[1]}, 20'h0);
        chkb(serial_req_allow_out, 1'h1);
        repeat (15) @(negedge clk_in);
        chkb(ram_flush_busy_out, 1'h1);
        @(negedge clk_in);
        chkb(ram_flush_busy_out, 1'h0);
        cmc_host_model_i.wr(8'h0C, 16'h8040);
        chkb(serial_req_allow_out, 1'h0);
        cfg_master_in[1:0] = {16'hBEEF, 16'h5A5A};
        cfg_write_in = 8'h03;
        @(negedge clk_in);
        cfg_write_in = 8'h00;
        repeat (2) @(negedge clk_in);
        chk({4'h0, cfg_slave_out[1]}, 20'h0);
        @(negedge clk_in);
        chk({4'h0, cfg_slave_out[1]}, 20'h0BEEF);
        chk({4'h0, cfg_slave_out[0]}, 20'h05A5A);
        parallel_mode_in = 1'h1;
        fifo_overflow_in = 1'h1;
        @(negedge clk_in);
        chkb(channel_reset_out, 1'h1);
        cmc_host_model_i.wr(8'h0C, 16'h8042);
        @(negedge clk_in);
        chkb(channel_reset_out, 1'h0);
        chkb(frz, 1'h0);
        $display("test updates and overflow done");
        cmc_host_model_i.wr(8'h0C, 16'h7000);
        chkb(gha, 1'h1);
        chkb(cha, 1'h1);
        ramp = 12'h0CD;
        s1 = 20'h54321;
        #1;
        chk(fi, 20'h0ABCD);
        @(negedge clk_in);
        chk({8'h0, gv}, 20'h000AB);
        cmc_host_model_i.wr(8'h0C, 16'h0028);
        chkb(serial_input_block, 1'h1);
        s1 = 20'h0;
        ext_tx_gate_pin_in = 1'h1;
        upd_pin = 1'h1;
        cfg_master_in[0] = 16'h7777;
        repeat (2) @(negedge clk_in);
        chkb(gate, 1'h1);
        chk({8'h0, gv}, 20'h000CD);
        @(negedge clk_in);
        chkb(flush, 1'h1);
        chk({4'h0, cfg_slave_out[0]}, 20'h07777);
        upd_pin = 1'h0;
        cmc_host_model_i.wr(8'h0C, 16'h0824);
        @(negedge clk_in);
        chkb(gate, 1'h0);
        chkb(frz, 1'h1);
        int_gate = 1'h1;
        @(negedge clk_in);
        chkb(gate, 1'h1);
        chkb(flush, 1'h0);
        cmc_host_model_i.wr(8'h0C, 16'h0804);
        chkb(gate, 1'h0);
        chkb(serial_input_block, 1'h0);
        $display("test gate, hold and delay done");
        stop_test();
    end
endmodule : cmc_main_ctrl_tb
`default_nettype wire
